/* src/fcd_host.v */
// Host controller that drives a parallel NOR flash through its pins
// Functional notes
// R1: Address steady before strobe falls, data steady through the strobe rise.
// R2: During embedded program, extra commands are ignored; host does not gate them and may send more.
// R3: During sector erase, only suspend is meaningful; host does not block other commands.
// R4: After suspend, device reads array until another command arrives.
// R5: When embedded task ends, full command set is again available.
// R6: Reset command is one write of F0 at any address.
// R7: Unlock cycles at 555/2AA word mode, AAA/555 byte mode.
// R8: Upper address bits are don't care except program and sector addresses.
// R9: Program is unlock pair, A0, then value at target address.
// R10: Erase is unlock, 80, unlock, then 10 chip or 30 sector.
// R11: Wrong or out-of-order writes drop the device back to read mode.
// R12: Suspend B0 and resume 30 are single writes, valid during sector erase.
// R13: After failure, write F0 then issue a valid new command.
// R14: In read mode, every read returns array data.
// R15: After unlock and 90, address 0 gives maker id, 1 part id.
// R16: Identifier read at sector offset 2 word / 4 byte gives protect state.
// R17: Protect unlock is six writes ending with 20; A17..A12 select sector. The host sends the 20 at the first unlock address.
// R18: Erase pre-program, pulses and verify run inside device unattended.
// R19: A status bit toggles on each read while embedded work runs.
// R20: Top data pin is data bit 15 in word mode, address LSB in byte mode.
// R21: Erase done only when bit 7 is 1 and bit 6 stops toggling twice.
// R22: Read is chip select, output gate low; write is chip select, strobe low.
// R23: Hardware reset floats outputs and returns decoder to read mode.
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "fcd_consts.vh"
module fcd_host (
    // Clock and reset
    input wire clock_in,
    input wire rstn_in,
    // Avalon-MM slave
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // Flash pins
    output reg [17:0] fl_addr_out,
    output reg fl_ce_n_out,
    output reg fl_oe_n_out,
    output reg fl_we_n_out,
    output reg fl_byte_n_out,
    output reg fl_reset_n_out,
    output reg [15:0] fl_dq_out,
    output reg fl_dq_oe_out,
    input wire [15:0] fl_dq_in,
    input wire ready_busy_bar_in
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_SETUP = 3'd1;
    localparam ST_PULSE = 3'd2;
    localparam ST_HOLD = 3'd3;
    localparam ST_NEXT = 3'd4;
    localparam ST_DONE = 3'd5;

    reg [2:0] state;
    reg [3:0] op;
    reg byte_mode;
    reg [18:0] target;
    reg [15:0] wdata;
    reg [15:0] rdata;
    reg [2:0] step;
    reg [2:0] nsteps;
    reg is_read;
    reg [3:0] tcnt;
    reg busy;
    reg poll_first;
    reg prev_q6;
    reg done_flag;
    reg fail_flag;
    reg [18:0] cyc_addr;
    reg [7:0] cyc_data;
    reg rd_pend; // Second cycle of a register read

    // Unlock addresses follow the width mode
    wire [18:0] ua1 = byte_mode ? `FCD_UA1_BYTE : `FCD_UA1_WORD; // R7
    wire [18:0] ua2 = byte_mode ? `FCD_UA2_BYTE : `FCD_UA2_WORD; // R7

    // ----------------------------------------
    // Sequence table: address and data of each step
    // ----------------------------------------
    always @* begin
        cyc_addr = ua1;
        cyc_data = `FCD_CMD_UNLK1;
        case (step)
            3'd0: begin
                cyc_addr = ua1;
                cyc_data = `FCD_CMD_UNLK1;
            end
            3'd1: begin
                cyc_addr = ua2;
                cyc_data = `FCD_CMD_UNLK2;
            end
            3'd2: begin
                cyc_addr = ua1;
                case (op)
                    `FCD_OP_ID: cyc_data = `FCD_CMD_ID; // R15
                    `FCD_OP_PROG: cyc_data = `FCD_CMD_PROG; // R9
                    default: cyc_data = `FCD_CMD_SETUP; // R10
                endcase
            end
            3'd3: begin
                // Fourth write: program value at target, else first unlock again
                cyc_addr = (op == `FCD_OP_PROG) ? target : ua1; // R9 R8
                cyc_data = (op == `FCD_OP_PROG) ? wdata[7:0] : `FCD_CMD_UNLK1;
            end
            3'd4: begin
                cyc_addr = ua2;
                cyc_data = `FCD_CMD_UNLK2;
            end
            default: begin
                case (op)
                    `FCD_OP_SECT: begin
                        cyc_addr = target; // R10 R8
                        cyc_data = `FCD_CMD_SECT;
                    end
                    `FCD_OP_UNLOCK: begin
                        cyc_addr = ua1;
                        cyc_data = `FCD_CMD_PROT; // R17
                    end
                    default: begin
                        cyc_addr = ua1;
                        cyc_data = `FCD_CMD_CHIP; // R10
                    end
                endcase
            end
        endcase
    end

    // Single-write commands go to any address; reads use the target
    wire single = (op == `FCD_OP_RESET) || (op == `FCD_OP_SUSP) || (op == `FCD_OP_RESUME);
    wire reading = (op == `FCD_OP_READ) || (op == `FCD_OP_POLL);
    wire [7:0] single_data = (op == `FCD_OP_SUSP) ? `FCD_CMD_SUSP :
                             (op == `FCD_OP_RESUME) ? `FCD_CMD_RESUME : `FCD_CMD_RESET; // R6 R12
    wire [18:0] drive_addr = (single || reading) ? target : cyc_addr;
    wire [7:0] drive_data = single ? single_data : cyc_data;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // Go is honoured only while idle; writes never stall
    wire go_req = avs_write_in && (avs_address_in == `FCD_REG_CTRL) && avs_writedata_in[`FCD_CTRL_GO];
    // Reads stall one cycle so the registered read data stand when the stall drops
    assign avs_waitrequest_out = avs_read_in && !rd_pend;

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avs_readdata_out <= 32'h0000_0000;
            rd_pend <= 1'b0;
        end else begin
            // Flips per read so each read sees exactly one stall cycle
            rd_pend <= avs_read_in && !rd_pend;
            // Data are captured once, then stand until the master takes them
            if (avs_read_in && !rd_pend) begin
                case (avs_address_in)
                    `FCD_REG_CTRL: avs_readdata_out <= {24'h000000, op, 2'b00, byte_mode, 1'b0};
                    `FCD_REG_ADDR: avs_readdata_out <= {13'h0000, target};
                    `FCD_REG_DATA: avs_readdata_out <= {rdata, wdata};
                    `FCD_REG_STAT: avs_readdata_out <= {28'h0000000, fail_flag, done_flag,
                                                        ~ready_busy_bar_in, busy};
                    default: avs_readdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Cycle engine
    // ----------------------------------------
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_IDLE;
            op <= `FCD_OP_RESET;
            byte_mode <= 1'b0;
            target <= 19'h00000;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
            step <= 3'd0;
            nsteps <= 3'd0;
            is_read <= 1'b0;
            tcnt <= 4'h0;
            busy <= 1'b0;
            poll_first <= 1'b0;
            prev_q6 <= 1'b0;
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
            fl_addr_out <= 18'h00000;
            fl_ce_n_out <= 1'b1;
            fl_oe_n_out <= 1'b1;
            fl_we_n_out <= 1'b1;
            fl_byte_n_out <= 1'b1;
            fl_reset_n_out <= 1'b0; // R23
            fl_dq_out <= 16'h0000;
            fl_dq_oe_out <= 1'b0;
        end else begin
            fl_reset_n_out <= 1'b1;
            case (state)
                ST_IDLE: begin
                    // Register writes are taken only while idle
                    if (avs_write_in && avs_address_in == `FCD_REG_ADDR)
                        target <= avs_writedata_in[18:0];
                    if (avs_write_in && avs_address_in == `FCD_REG_DATA)
                        wdata <= avs_writedata_in[15:0];
                    if (go_req && !busy) begin
                        op <= avs_writedata_in[`FCD_CTRL_OP_HI:`FCD_CTRL_OP_LO];
                        byte_mode <= avs_writedata_in[`FCD_CTRL_BYTE];
                        fl_byte_n_out <= ~avs_writedata_in[`FCD_CTRL_BYTE];
                        busy <= 1'b1;
                        done_flag <= 1'b0;
                        step <= 3'd0;
                        poll_first <= 1'b1;
                        case (avs_writedata_in[`FCD_CTRL_OP_HI:`FCD_CTRL_OP_LO])
                            // Identifier entry stops after the command byte; a fourth
                            // write would open a stray unlock sequence in the device
                            `FCD_OP_ID: nsteps <= 3'd2; // R15
                            `FCD_OP_PROG: nsteps <= 3'd3; // R9
                            `FCD_OP_CHIP, `FCD_OP_SECT, `FCD_OP_UNLOCK: nsteps <= 3'd5; // R10 R17
                            default: nsteps <= 3'd0;
                        endcase
                        state <= ST_SETUP;
                        tcnt <= 4'h0;
                    end
                end
                ST_SETUP: begin
                    // Address and write data settle before the strobe falls
                    is_read <= reading;
                    fl_addr_out <= byte_mode ? drive_addr[18:1] : drive_addr[17:0];
                    fl_dq_out <= byte_mode ? {drive_addr[0], 7'h00, drive_data} // R20
                                           : (single ? {8'h00, drive_data}
                                              : ((op == `FCD_OP_PROG && step == 3'd3)
                                                 ? wdata : {8'h00, drive_data}));
                    // Byte mode keeps the whole data bus driven on reads, since the top pin carries the address LSB
                    fl_dq_oe_out <= byte_mode ? 1'b1 : !reading; // R22
                    fl_ce_n_out <= 1'b0;
                    tcnt <= tcnt + 4'h1;
                    if (tcnt == `FCD_T_SETUP) begin
                        tcnt <= 4'h0;
                        fl_oe_n_out <= !reading; // R22
                        fl_we_n_out <= reading; // R1 R22
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    tcnt <= tcnt + 4'h1;
                    if (tcnt == `FCD_T_PULSE) begin
                        tcnt <= 4'h0;
                        // Read data sampled at the last low clock of the output gate
                        if (is_read)
                            rdata <= byte_mode ? {8'h00, fl_dq_in[7:0]} : fl_dq_in; // R14
                        fl_oe_n_out <= 1'b1;
                        fl_we_n_out <= 1'b1; // R1: data held past this rise
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Select and data outlast the strobe so the device latches clean values
                    tcnt <= tcnt + 4'h1;
                    if (tcnt == `FCD_T_HOLD) begin
                        tcnt <= 4'h0;
                        fl_ce_n_out <= 1'b1;
                        fl_dq_oe_out <= 1'b0;
                        state <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    state <= ST_SETUP;
                    if (op == `FCD_OP_POLL) begin
                        // Busy while bit 6 still flips between reads
                        poll_first <= 1'b0;
                        prev_q6 <= rdata[6];
                        if (rdata[5] && !poll_first)
                            fail_flag <= 1'b1; // R13: software then sends reset
                        if (!poll_first && rdata[6] == prev_q6 && rdata[7])
                            state <= ST_DONE; // R19 R21
                        else if (rdata[5] && !poll_first)
                            state <= ST_DONE;
                    end else if (step == nsteps) begin
                        state <= ST_DONE;
                    end else begin
                        step <= step + 3'd1;
                    end
                    if (op == `FCD_OP_RESET)
                        fail_flag <= 1'b0; // R13
                end
                ST_DONE: begin
                    // Done is sticky until the next go, so software may poll late
                    busy <= 1'b0;
                    done_flag <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // fcd_host

/* src/fcd_consts.vh */
// Constants for the flash command host controller
`ifndef FCD_CONSTS_VH
`define FCD_CONSTS_VH
// Host register word offsets (byte addresses)
`define FCD_REG_CTRL 4'h0
`define FCD_REG_ADDR 4'h4
`define FCD_REG_DATA 4'h8
`define FCD_REG_STAT 4'hc
// Control register fields
`define FCD_CTRL_GO 0
`define FCD_CTRL_BYTE 1
`define FCD_CTRL_OP_LO 4
`define FCD_CTRL_OP_HI 7
// Operation codes
`define FCD_OP_RESET 4'h0
`define FCD_OP_READ 4'h1
`define FCD_OP_ID 4'h2
`define FCD_OP_PROG 4'h3
`define FCD_OP_CHIP 4'h4
`define FCD_OP_SECT 4'h5
`define FCD_OP_SUSP 4'h6
`define FCD_OP_RESUME 4'h7
`define FCD_OP_UNLOCK 4'h8
`define FCD_OP_POLL 4'h9
// Command bytes
`define FCD_CMD_RESET 8'hf0
`define FCD_CMD_UNLK1 8'haa
`define FCD_CMD_UNLK2 8'h55
`define FCD_CMD_ID 8'h90
`define FCD_CMD_PROG 8'ha0
`define FCD_CMD_SETUP 8'h80
`define FCD_CMD_CHIP 8'h10
`define FCD_CMD_SECT 8'h30
`define FCD_CMD_SUSP 8'hb0
`define FCD_CMD_RESUME 8'h30
`define FCD_CMD_PROT 8'h20
// Unlock addresses, word and byte mode
`define FCD_UA1_WORD 19'h00555
`define FCD_UA2_WORD 19'h002aa
`define FCD_UA1_BYTE 19'h00aaa
`define FCD_UA2_BYTE 19'h00555
// Bus cycle phase terminal counts; each phase lasts the count plus one clock cycles (10 ns each)
`define FCD_T_SETUP 4'h3
`define FCD_T_PULSE 4'h6
`define FCD_T_HOLD 4'h3
`endif

/* testbench/fcd_host_chk.sv */
// Pin protocol checker for the flash host controller
`timescale 1ns/1ps
module fcd_host_chk (
    // Clock and reset
    input wire clock_in,
    input wire rstn_in,
    // Flash pins
    input wire [17:0] fl_addr_out,
    input wire fl_ce_n_out,
    input wire fl_oe_n_out,
    input wire fl_we_n_out,
    input wire fl_byte_n_out,
    input wire fl_reset_n_out,
    input wire [15:0] fl_dq_out,
    input wire fl_dq_oe_out
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    property p_rw_apart; fl_we_n_out || fl_oe_n_out; endproperty
    a_rw_apart: assert property (p_rw_apart) else $error("both strobes low");
    property p_we_sel; !fl_we_n_out |-> !fl_ce_n_out; endproperty
    a_we_sel: assert property (p_we_sel) else $error("write without select");
    property p_wr_drive; !fl_we_n_out |-> fl_dq_oe_out; endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
    property p_rd_float; !fl_oe_n_out |-> !fl_dq_oe_out; endproperty
    a_rd_float: assert property (p_rd_float) else $error("drive during read");
    property p_pulse; $fell(fl_we_n_out) |-> (!fl_we_n_out)[*7] ##1 fl_we_n_out; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse length wrong");
    // Address must settle under select before the fall; address and data hold through the rise
    property p_setup; $fell(fl_we_n_out) |-> !$past(fl_ce_n_out) && $stable(fl_addr_out);
    endproperty
    a_setup: assert property (p_setup) else $error("address not set up");
    property p_hold; $rose(fl_we_n_out) |-> $stable(fl_addr_out) && $stable(fl_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("write not held");
    property p_hw_reset; !fl_reset_n_out |-> fl_we_n_out && fl_oe_n_out && !fl_dq_oe_out;
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("pins active in reset");
    property p_unlock1; $fell(fl_we_n_out) && fl_dq_out[7:0] == 8'haa |-> (fl_byte_n_out ?
        fl_addr_out[10:0] == 11'h555 : {fl_addr_out[10:0], fl_dq_out[15]} == 12'haaa);
    endproperty
    a_unlock1: assert property (p_unlock1) else $error("first unlock address");
    property p_unlock2; $fell(fl_we_n_out) && fl_dq_out[7:0] == 8'h55 |-> (fl_byte_n_out ?
        fl_addr_out[10:0] == 11'h2aa : {fl_addr_out[10:0], fl_dq_out[15]} == 12'h555);
    endproperty
    a_unlock2: assert property (p_unlock2) else $error("second unlock address");
    c_byte_unlock: cover property ($fell(fl_we_n_out) && !fl_byte_n_out);
    c_sector: cover property ($fell(fl_we_n_out) && fl_dq_out[7:0] == 8'h30);
    c_read: cover property ($fell(fl_oe_n_out));
endmodule // fcd_host_chk

/* testbench/fcd_flash_mdl.sv */
// Behavioural model of the parallel flash behind the host controller
`timescale 1ns/1ps
module fcd_flash_mdl #(
    parameter [15:0] MAKER = 16'h0012, // Arbitrary value
    parameter [15:0] PART = 16'h0345 // Arbitrary value
) (
    // Flash pins
    input wire [17:0] addr_in,
    input wire ce_n_in,
    input wire oe_n_in,
    input wire we_n_in,
    input wire byte_n_in,
    input wire reset_n_in,
    input wire [15:0] dq_in,
    output reg [15:0] dq_out,
    output wire ready_busy_bar_out
);
    reg [15:0] mem [0:15];
    reg [11:0] ua;
    reg [3:0] wa;
    reg [2:0] cyc = 0;
    reg [1:0] cnt = 0;
    reg idm = 0, busy = 0, era = 0, ers = 0, susp = 0, tog = 0;
    integer i;
    wire [7:0] d = dq_in[7:0];
    wire [11:0] u1 = byte_n_in ? 12'h555 : 12'haaa;
    wire [11:0] u2 = byte_n_in ? 12'h2aa : 12'h555;
    assign ready_busy_bar_out = ~busy;
    initial begin
        dq_out = 16'h0;
        for (i = 0; i < 16; i = i + 1) mem[i] = 16'hffff;
    end
    // ----------------------------------------
    // Command decoder
    // ----------------------------------------
    // Address latched on the fall; upper bits never reach the unlock compare
    always @(negedge we_n_in) if (!ce_n_in) begin
        ua = byte_n_in ? {1'b0, addr_in[10:0]} : {addr_in[10:0], dq_in[15]};
        wa = addr_in[3:0];
    end
    // Data latched on the rise; any mismatch falls back to read mode
    always @(posedge we_n_in) if (!ce_n_in && reset_n_in) begin
        if (busy) begin
            if (era && d == 8'hb0) {busy, susp} = 2'b01;
        end else if (d == 8'hf0) {cyc, idm} = 0;
        else if (susp && cyc == 0 && d == 8'h30) {busy, susp} = 2'b10;
        else case (cyc)
            3'd0: cyc = (ua == u1 && d == 8'haa) ? 3'd1 : 3'd0;
            3'd1: cyc = (ua == u2 && d == 8'h55) ? 3'd2 : 3'd0;
            3'd2: begin
                idm = ua == u1 && d == 8'h90;
                cyc = ua != u1 ? 3'd0 : d == 8'ha0 ? 3'd3 : d == 8'h80 ? 3'd4 : 3'd0;
            end
            3'd3: begin
                mem[wa] = mem[wa] & dq_in;
                {cyc, busy, era, ers, cnt} = 8'b00010011;
            end
            3'd4: cyc = (ua == u1 && d == 8'haa) ? 3'd5 : 3'd0;
            3'd5: cyc = (ua == u2 && d == 8'h55) ? 3'd6 : 3'd0;
            default: begin // protect unlock ends here with no action
                cyc = 0;
                if ((d == 8'h10 && ua == u1) || d == 8'h30) {busy, era, ers, cnt} = {3'b1_1_1, 2'd3};
                era = busy && d == 8'h30;
            end
        endcase
    end
    // Reads: toggling status while busy, codes in id mode, else array; released pins flip
    always @(oe_n_in or ce_n_in or reset_n_in) begin
        if (!reset_n_in) begin
            {cyc, idm, busy, ers, susp} = 0;
            dq_out = ~dq_out;
        end else if (!oe_n_in && !ce_n_in) begin
            if (busy) begin
                tog = ~tog;
                dq_out = {8'h00, 1'b0, tog, 6'h00};
                cnt = cnt - 2'd1;
                if (cnt == 0) busy = 0;
                if (cnt == 0 && ers) for (i = 0; i < 16; i = i + 1) mem[i] = 16'hffff;
            end else if (idm) dq_out = addr_in[1] ? 16'h0000 : addr_in[0] ? PART : MAKER;
            else dq_out = mem[addr_in[3:0]];
        end else dq_out = ~dq_out;
    end
endmodule // fcd_flash_mdl

/* testbench/fcd_host_tb.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "fcd_consts.vh"
module fcd_host_tb;
    localparam [15:0] MAKER = 16'h0012; // Arbitrary value
    localparam [15:0] PART = 16'h0345; // Arbitrary value
    reg clock_in, rstn_in, av_rd, av_wr;
    reg [3:0] av_addr, a;
    reg [31:0] av_wd, rv;
    reg [15:0] sh [0:15];
    reg [15:0] v;
    wire [31:0] av_rdd;
    wire av_wait, ce_n, oe_n, we_n, byte_n, frst_n, dq_oe, rbb;
    wire [17:0] fa;
    wire [15:0] dqo, dqm;
    wire [15:0] dq_bus = dq_oe ? dqo : dqm; // Resolved data wire
    integer n_errors, comparisons, i;
    fcd_host u_fcd_host (.clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(av_addr),
        .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wd),
        .avs_readdata_out(av_rdd), .avs_waitrequest_out(av_wait), .fl_addr_out(fa),
        .fl_ce_n_out(ce_n), .fl_oe_n_out(oe_n), .fl_we_n_out(we_n), .fl_byte_n_out(byte_n),
        .fl_reset_n_out(frst_n), .fl_dq_out(dqo), .fl_dq_oe_out(dq_oe), .fl_dq_in(dq_bus),
        .ready_busy_bar_in(rbb));
    fcd_flash_mdl #(.MAKER(MAKER), .PART(PART)) u_fcd_flash_mdl (.addr_in(fa), .ce_n_in(ce_n),
        .oe_n_in(oe_n), .we_n_in(we_n), .byte_n_in(byte_n), .reset_n_in(frst_n),
        .dq_in(dq_bus), .dq_out(dqm), .ready_busy_bar_out(rbb));
    initial begin
        clock_in = 0;
        forever #5 clock_in = ~clock_in;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function [15:0] f_id(input [1:0] ad);
        f_id = ad[1] ? 16'h0000 : ad[0] ? PART : MAKER;
    endfunction
    task chk(input [31:0] seen, input [31:0] exp); begin
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end endtask
    // Request held until the edge at which waitrequest is low; read data taken there
    task bus(input wr, input [3:0] ad, input [31:0] dt); begin
        @(posedge clock_in);
        {av_addr, av_wd, av_wr, av_rd} <= {ad, dt, wr, !wr};
        #1;
        while (av_wait !== 1'b0) begin
            @(posedge clock_in);
            #1;
        end
        rv = av_rdd;
        @(posedge clock_in);
        {av_wr, av_rd} <= 2'b00;
    end endtask
    task op(input [3:0] code, input bm, input [3:0] ad, input [15:0] dt); integer k; begin
        bus(1, `FCD_REG_ADDR, {28'h0, ad});
        bus(1, `FCD_REG_DATA, {16'h0, dt});
        bus(1, `FCD_REG_CTRL, {24'h0, code, 2'b00, bm, 1'b1});
        rv = 32'h1;
        for (k = 0; rv[0] !== 1'b0 && k < 2000; k = k + 1) bus(0, `FCD_REG_STAT, 0);
        if (k == 2000) n_errors = n_errors + 1;
    end endtask
    task rdw(input [3:0] ad); begin
        op(`FCD_OP_READ, 0, ad, 0);
        bus(0, `FCD_REG_DATA, 0);
    end endtask
    task prog(input [3:0] ad, input [15:0] dt); begin
        op(`FCD_OP_PROG, 0, ad, dt);
        op(`FCD_OP_POLL, 0, ad, 0);
        sh[ad] = sh[ad] & dt;
    end endtask
    task print_verdict; begin
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end endtask
    initial begin
        #500000;
        n_errors = n_errors + 1;
        print_verdict;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rstn_in, av_rd, av_wr, av_addr, av_wd, n_errors, comparisons} = 0;
        for (i = 0; i < 16; i = i + 1) sh[i] = 16'hffff;
        v = $urandom(61717);
        repeat (10) @(posedge clock_in);
        rstn_in <= 1;
        // Random programs; bit 7 and bit 0 set keep values off the unlock bytes
        for (i = 0; i < 6; i = i + 1) begin
            a = $urandom % 16;
            prog(a, $urandom | 16'h0081);
            rdw(a);
            chk(rv[31:16], sh[a]);
        end
        op(`FCD_OP_PROG, 0, 5, 16'h0f81);
        sh[5] = sh[5] & 16'h0f81;
        op(`FCD_OP_SUSP, 0, 0, 0);
        op(`FCD_OP_POLL, 0, 5, 0);
        bus(1, 4'h2, 32'hffffffff);
        rdw(5);
        chk(rv[31:16], sh[5]);
        op(`FCD_OP_ID, 0, 0, 0);
        for (i = 0; i < 3; i = i + 1) begin
            rdw(i[3:0]);
            chk(rv[31:16], f_id(i[1:0]));
        end
        op(`FCD_OP_RESET, 0, 0, 0);
        rdw(5);
        chk(rv[31:16], sh[5]);
        op(`FCD_OP_UNLOCK, 1, 0, 0);
        op(`FCD_OP_RESET, 1, 0, 0);
        op(`FCD_OP_ID, 1, 0, 0);
        op(`FCD_OP_RESET, 0, 0, 0);
        op(`FCD_OP_CHIP, 0, 0, 0);
        op(`FCD_OP_POLL, 0, 5, 0);
        rdw(5);
        chk(rv[31:16], 16'hffff);
        for (i = 0; i < 16; i = i + 1) sh[i] = 16'hffff;
        prog(7, 16'h1281);
        op(`FCD_OP_SECT, 0, 7, 0);
        op(`FCD_OP_PROG, 0, 3, 16'h0081);
        op(`FCD_OP_SUSP, 0, 0, 0);
        rdw(7);
        chk(rv[31:16], sh[7]);
        rdw(3);
        chk(rv[31:16], sh[3]);
        op(`FCD_OP_RESUME, 0, 0, 0);
        op(`FCD_OP_POLL, 0, 7, 0);
        rdw(7);
        chk(rv[31:16], 16'hffff);
        sh[7] = 16'hffff;
        prog(9, 16'h3381);
        op(`FCD_OP_SECT, 0, 9, 0);
        rstn_in <= 0;
        repeat (3) @(posedge clock_in);
        rstn_in <= 1;
        rdw(9);
        chk(rv[31:16], sh[9]);
        print_verdict;
    end
endmodule // fcd_host_tb
bind fcd_host fcd_host_chk u_fcd_host_chk (.clock_in(clock_in), .rstn_in(rstn_in),
    .fl_addr_out(fl_addr_out), .fl_ce_n_out(fl_ce_n_out), .fl_oe_n_out(fl_oe_n_out),
    .fl_we_n_out(fl_we_n_out), .fl_byte_n_out(fl_byte_n_out), .fl_reset_n_out(fl_reset_n_out),
    .fl_dq_out(fl_dq_out), .fl_dq_oe_out(fl_dq_oe_out));
